// ### sim/adc_conversion_sequencer_test.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_conversion_sequencer_test
  import adc_seq_pkg::*;
();
  localparam int CONV_N = 50;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, err, pready, pslverr, raw_valid, ref_to_pin;
  logic converter_power, modulator_run, conv_done_irq;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [RAW_W-1:0] raw_data;
  logic [NUM_INPUTS-1:0] input_switch_en;
  logic [1:0] ref_level;
  int n_mismatch = 0, cmp_count = 0, cyc;
  realtime t_go, t0;
  always #12.5 pclk = ~pclk;
  adc_conversion_sequencer #(.CONV_CYCLES(13'(CONV_N))) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_data(raw_data), .raw_valid(raw_valid),
    .converter_power(converter_power), .modulator_run(modulator_run),
    .input_switch_en(input_switch_en), .ref_level(ref_level),
    .ref_to_pin(ref_to_pin), .conv_done_irq(conv_done_irq));
  front_end_model fe (.pclk(pclk), .presetn(presetn),
    .modulator_run(modulator_run), .input_switch_en(input_switch_en),
    .raw_data(raw_data), .raw_valid(raw_valid));
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [13:0] idx,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    t_go = $realtime;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [13:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask
  // Cycles from t to the interrupt pulse, sampled after the edge settles
  task automatic wait_irq(input realtime t, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge pclk);
      #1;
      if (conv_done_irq === 1'b1) break;
    end
    cyc = int'(($realtime - 1.0 - t) / 25.0);
  endtask
  task automatic res_chk(input logic [2:0] ch);
    logic [12:0] r;
    r = {ch, 10'h1C7};
    rdchk(RES_HI_IDX, r[12:5]);
    rdchk(RES_LO_IDX, {r[4:0], 3'h0});
  endtask
  task automatic t_reset();
    rdchk(CTL0_IDX, CTL0_RESET);
    rdchk(CTL1_IDX, 8'h80);
    rdchk(RES_LO_IDX, RESULT_RESET);
    `CHK(ref_level, 2'h2)
    apb(1'b0, 14'h0100, 8'h00);
    `CHK({err, rd}, 33'h100000000)
  endtask
  task automatic t_single();
    // Reference level first, then select and go in one write
    apb(1'b1, CTL1_IDX, 8'h80);
    apb(1'b1, CTL0_IDX, 8'h83);
    t0 = t_go;
    rdchk(CTL0_IDX, 8'h83);
    repeat (45) @(posedge pclk);
    #1;
    `CHK({modulator_run, input_switch_en}, 9'h108)
    wait_irq(t0, 6000);
    `CHK(cyc, 40 + CONV_N)
    t0 = $realtime - 1.0;
    @(posedge pclk);
    #1;
    `CHK({conv_done_irq, modulator_run}, 2'h0)
    rdchk(CTL0_IDX, 8'h03);
    res_chk(3'h3);
    for (int i = 0; i < 400 && converter_power === 1'b1; i++) begin
      @(posedge pclk);
      #1;
    end
    `CHK(int'(($realtime - 1.0 - t0) / 25.0), 160)
  endtask
  // Restart in mid-conversion, then a go of zero, then a start when ready
  task automatic t_restart();
    apb(1'b1, CTL0_IDX, 8'h83);
    repeat (50) @(posedge pclk);
    apb(1'b1, CTL0_IDX, 8'h83);
    t0 = t_go;
    repeat (5) @(posedge pclk);
    apb(1'b1, CTL0_IDX, 8'h03);
    wait_irq(t0, 6000);
    `CHK(cyc, CONV_N)
    apb(1'b1, CTL0_IDX, 8'h83);
    wait_irq(t_go, 6000);
    `CHK(cyc, CONV_N)
  endtask
  task automatic t_repeat();
    apb(1'b1, CTL0_IDX, 8'h95);
    wait_irq(t_go, 6000);
    `CHK(cyc, CONV_N)
    t0 = $realtime - 1.0;
    rdchk(CTL0_IDX, 8'h15);
    res_chk(3'h5);
    repeat (2) begin
      wait_irq(t0, 600);
      `CHK(cyc, 256)
      t0 = $realtime - 1.0;
    end
    rdchk(CTL0_IDX, 8'h15);
    apb(1'b1, CTL0_IDX, 8'h05);
    wait_irq(t_go, 300);
    `CHK({conv_done_irq, modulator_run}, 2'h0)
  endtask
  task automatic t_reserved();
    apb(1'b1, CTL0_IDX, 8'h8A);
    t0 = t_go;
    repeat (60) @(posedge pclk);
    #1;
    `CHK({modulator_run, input_switch_en}, 9'h100)
    wait_irq(t0, 6000);
    `CHK(cyc, 40 + CONV_N)
    // No valid strobe with open switches: last valid sample is kept
    res_chk(3'h5);
  endtask
  task automatic t_ref();
    apb(1'b1, CTL1_IDX, 8'h7F);
    rdchk(CTL1_IDX, 8'h00);
    `CHK(ref_level, 2'h0)
    apb(1'b1, CTL0_IDX, 8'h40);
    #1;
    `CHK({ref_level, ref_to_pin}, 3'h2)
    apb(1'b1, CTL1_IDX, 8'h80);
    apb(1'b1, CTL0_IDX, 8'h20);
    #1;
    `CHK({ref_level, ref_to_pin}, 3'h5)
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence after a 20-cycle reset
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_single();
    t_restart();
    t_repeat();
    t_reserved();
    t_ref();
    finish_test();
  end
  // Watchdog, several times the expected run length
  initial begin
    #300000;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire

// ### sim/adc_seq_asserts.sv
// Port checker for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_asserts
  import adc_seq_pkg::*;
#(
  parameter logic [12:0] CONV_CYCLES = CONV_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic converter_power,
  input wire logic modulator_run,
  input wire logic [NUM_INPUTS-1:0] input_switch_en,
  input wire logic [1:0] ref_level,
  input wire logic ref_to_pin,
  input wire logic conv_done_irq
);
  logic acc, wr0, wr1, first_ff, nxt_first;
  logic [13:0] cnt_ff, nxt_cnt;
  logic [7:0] idle_ff, nxt_idle, exp_sw;
  logic [3:0] sel_ff, nxt_sel;
  logic [2:0] ref_ff, nxt_ref;
  assign acc = psel && penable && pready;
  assign wr0 = acc && pwrite && pstrb[0] && paddr == {CTL0_IDX, 2'h0};
  assign wr1 = acc && pwrite && pstrb[0] && paddr == {CTL1_IDX, 2'h0};
  // Mirror of control fields; cnt counts from go, idle from last activity
  always_comb begin
    nxt_cnt = (cnt_ff == 14'h3FFF) ? cnt_ff : cnt_ff + 14'h0001;
    nxt_idle = (converter_power && !modulator_run) ? idle_ff + 8'h01 : 8'h00;
    nxt_first = conv_done_irq ? 1'b0 : first_ff;
    nxt_sel = wr0 ? pwdata[3:0] : sel_ff;
    nxt_ref = wr0 ? {ref_ff[2], pwdata[6:5]} : ref_ff;
    if (wr1) begin
      nxt_ref[2] = pwdata[7];
    end
    if (wr0 && pwdata[GO_BIT]) begin
      nxt_cnt = 14'h0000;
      nxt_first = 1'b1;
    end
    exp_sw = 8'h00;
    if (modulator_run && !sel_ff[3]) begin
      exp_sw[sel_ff[2:0]] = 1'b1;
    end
  end
  // Mirror registers, reset to the documented control defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 14'h0000;
      idle_ff <= 8'h00;
      first_ff <= 1'b0;
      sel_ff <= 4'h0;
      ref_ff <= 3'h4;
    end else begin
      cnt_ff <= nxt_cnt;
      idle_ff <= nxt_idle;
      first_ff <= nxt_first;
      sel_ff <= nxt_sel;
      ref_ff <= nxt_ref;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_irq_one_cycle: assert property (conv_done_irq |=> !conv_done_irq)
    else $error("interrupt longer than one cycle");
  a_irq_while_run: assert property (
    $rose(conv_done_irq) |-> $past(modulator_run))
    else $error("interrupt without running converter");
  a_powerup_len: assert property (
    $rose(modulator_run) |-> $past(converter_power, 40))
    else $error("conversion began before power-up finished");
  a_conv_length: assert property ($rose(conv_done_irq) && first_ff |->
    cnt_ff == {1'b0, CONV_CYCLES} ||
    cnt_ff == {1'b0, CONV_CYCLES} + 14'h0028)
    else $error("conversion length wrong");
  a_repeat_gap: assert property (
    $rose(conv_done_irq) && !first_ff |-> $past(conv_done_irq, 256))
    else $error("repeat result spacing wrong");
  a_go_reads: assert property (
    acc && !pwrite && paddr == {CTL0_IDX, 2'h0} |->
    prdata[GO_BIT] == first_ff)
    else $error("go bit reads wrong");
  a_switch_sel: assert property (input_switch_en == exp_sw)
    else $error("input switches wrong");
  a_ref_fields: assert property ({ref_level, ref_to_pin} == ref_ff)
    else $error("reference outputs wrong");
  a_power_down: assert property (
    $fell(converter_power) |-> idle_ff == 8'hA0)
    else $error("power-down not after idle span");
  a_idle_bound: assert property (idle_ff <= 8'hA0)
    else $error("converter stayed powered too long");
  c_repeat: cover property ($rose(conv_done_irq) && !first_ff);
  c_restart: cover property (wr0 && pwdata[GO_BIT] && modulator_run);
  c_off: cover property ($fell(converter_power));
endmodule
bind adc_conversion_sequencer adc_seq_asserts #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .converter_power(converter_power),
  .modulator_run(modulator_run), .input_switch_en(input_switch_en),
  .ref_level(ref_level), .ref_to_pin(ref_to_pin),
  .conv_done_irq(conv_done_irq));
`default_nettype wire

// ### sim/front_end_model.sv
// Behavioural modulator and filter front end feeding raw samples
`timescale 1ns/1ps
`default_nettype none
module front_end_model
  import adc_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic modulator_run,
  input wire logic [NUM_INPUTS-1:0] input_switch_en,
  output logic [RAW_W-1:0] raw_data,
  output logic raw_valid
);
  logic [2:0] chan;
  // Channel number of the closed switch
  always_comb begin
    chan = 3'h0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (input_switch_en[i]) begin
        chan = 3'(i);
      end
    end
  end
  // Toggle the bus when idle so a stale value never passes for a sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_data <= 13'h0000;
      raw_valid <= 1'b0;
    end else if (modulator_run && (|input_switch_en)) begin
      raw_data <= {chan, 10'h1C7};
      raw_valid <= 1'b1;
    end else begin
      raw_data <= ~raw_data;
      raw_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verilog/adc_conversion_sequencer.sv
// Conversion sequencer for the sigma-delta converter, with APB registers
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter logic [12:0] CONV_CYCLES = CONV_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [RAW_W-1:0] raw_data,
  input wire logic raw_valid,
  output logic converter_power,
  output logic modulator_run,
  output logic [NUM_INPUTS-1:0] input_switch_en,
  output logic [1:0] ref_level,
  output logic ref_to_pin,
  output logic conv_done_irq
);

  // Register state
  logic conversion_go_ff, ref_level_lo_ff, ref_to_pin_ff, repeat_mode_ff;
  logic [3:0] input_select_ff;
  logic ref_level_hi_ff;
  logic [7:0] result_high_byte_ff;
  logic [7:0] result_low_byte_ff;
  logic [RAW_W-1:0] raw_hold_ff;
  logic irq_ff;
  logic [31:0] prdata_ff;
  logic nxt_conversion_go, nxt_ref_level_lo, nxt_ref_to_pin, nxt_repeat_mode;
  logic [3:0] nxt_input_select;
  logic nxt_ref_level_hi;
  logic [7:0] nxt_result_high_byte;
  logic [7:0] nxt_result_low_byte;
  logic [RAW_W-1:0] nxt_raw_hold;
  logic nxt_irq;
  logic [31:0] nxt_prdata;

  // Sequencer state
  seq_state_t state_ff;
  seq_state_t nxt_state;

  // Bus decode
  logic sel_ctl0, sel_ctl1, sel_res_hi, sel_res_lo, sel_status;
  logic mapped, wr_access, wr_ctl0, wr_ctl1, go_start;

  // Counter controls
  logic seq_load, seq_clear, seq_expired, complete;
  logic [CNT_W-1:0] seq_value;
  logic idle_load, idle_clear, idle_expired;
  logic [RAW_W-1:0] sample;

  // Address decode: word-aligned, index is the byte address over four
  always_comb begin
    sel_ctl0 = (paddr[15:2] == CTL0_IDX) && (paddr[1:0] == 2'b00);
    sel_ctl1 = (paddr[15:2] == CTL1_IDX) && (paddr[1:0] == 2'b00);
    sel_res_hi = (paddr[15:2] == RES_HI_IDX) && (paddr[1:0] == 2'b00);
    sel_res_lo = (paddr[15:2] == RES_LO_IDX) && (paddr[1:0] == 2'b00);
    sel_status = (paddr[15:2] == STATUS_IDX) && (paddr[1:0] == 2'b00);
    mapped = sel_ctl0 | sel_ctl1 | sel_res_hi | sel_res_lo | sel_status;
  end

  // Zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Writes take effect on the access edge, only via byte lane 0
  assign wr_access = psel && penable && pwrite && mapped && pstrb[0];
  assign wr_ctl0 = wr_access && sel_ctl0;
  assign wr_ctl1 = wr_access && sel_ctl1;
  // Only a written one starts or restarts; a zero leaves it alone
  assign go_start = wr_ctl0 && pwdata[GO_BIT];

  // Latest sample from the front end, used when the count runs out
  assign sample = raw_valid ? raw_data : raw_hold_ff;

  // A result only from converting states; a restart or stop wins
  assign complete = seq_expired && !go_start &&
                    ((state_ff == ST_CONV) ||
                     ((state_ff == ST_REPEAT) && repeat_mode_ff));

  // Sequencer next state and counter loads
  always_comb begin
    nxt_state = state_ff;
    seq_load = 1'b0;
    seq_value = CONV_CYCLES;
    seq_clear = 1'b0;
    unique case (state_ff)
      ST_OFF: begin
        if (go_start) begin
          nxt_state = ST_PWRUP;
          seq_load = 1'b1;
          seq_value = PWRUP_CYCLES;
        end
      end
      ST_PWRUP: begin
        if (go_start) begin
          seq_load = 1'b1;
          seq_value = PWRUP_CYCLES;
        end else if (seq_expired) begin
          nxt_state = ST_CONV;
          seq_load = 1'b1;
          seq_value = CONV_CYCLES;
        end
      end
      ST_CONV: begin
        if (go_start) begin
          seq_load = 1'b1;
          seq_value = CONV_CYCLES;
        end else if (seq_expired) begin
          if (repeat_mode_ff) begin
            nxt_state = ST_REPEAT;
            seq_load = 1'b1;
            seq_value = REPEAT_CYCLES;
          end else begin
            nxt_state = ST_READY;
            seq_clear = 1'b1;
          end
        end
      end
      ST_REPEAT: begin
        if (go_start) begin
          nxt_state = ST_CONV;
          seq_load = 1'b1;
          seq_value = CONV_CYCLES;
        end else if (!repeat_mode_ff) begin
          // Stop at once; a result already due is not written
          nxt_state = ST_READY;
          seq_clear = 1'b1;
        end else if (seq_expired) begin
          seq_load = 1'b1;
          seq_value = REPEAT_CYCLES;
        end
      end
      ST_READY: begin
        if (go_start) begin
          // Still powered, so no power-up time is spent
          nxt_state = ST_CONV;
          seq_load = 1'b1;
          seq_value = CONV_CYCLES;
        end else if (idle_expired) begin
          nxt_state = ST_OFF;
        end
      end
      default: begin
        nxt_state = ST_OFF;
        seq_clear = 1'b1;
      end
    endcase
  end

  // Idle timer restarts each time the sequencer falls idle
  assign idle_load = (nxt_state == ST_READY) && (state_ff != ST_READY);
  assign idle_clear = (state_ff != ST_READY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Power-up, conversion and repeat spacing share one counter
  cycle_counter u_seq_counter (
    .pclk(pclk),
    .presetn(presetn),
    .load(seq_load),
    .clear(seq_clear),
    .load_value(seq_value),
    .expired(seq_expired)
  );

  // Counts idle cycles before automatic power-down
  cycle_counter u_idle_counter (
    .pclk(pclk),
    .presetn(presetn),
    .load(idle_load),
    .clear(idle_clear),
    .load_value(IDLE_CYCLES),
    .expired(idle_expired)
  );

  // Control fields, go bit and results
  always_comb begin
    nxt_ref_level_lo = ref_level_lo_ff;
    nxt_ref_to_pin = ref_to_pin_ff;
    nxt_repeat_mode = repeat_mode_ff;
    nxt_input_select = input_select_ff;
    nxt_ref_level_hi = ref_level_hi_ff;
    nxt_conversion_go = conversion_go_ff;
    nxt_result_high_byte = result_high_byte_ff;
    nxt_result_low_byte = result_low_byte_ff;
    nxt_raw_hold = raw_valid ? raw_data : raw_hold_ff;
    nxt_irq = 1'b0;
    if (wr_ctl0) begin
      nxt_ref_level_lo = pwdata[REF_LO_BIT];
      nxt_ref_to_pin = pwdata[REF_PIN_BIT];
      nxt_repeat_mode = pwdata[REPEAT_BIT];
      nxt_input_select = pwdata[SEL_MSB:SEL_LSB];
    end
    if (wr_ctl1) begin
      nxt_ref_level_hi = pwdata[REF_HI_BIT];
    end
    if (complete) begin
      // 11-bit signed result in high byte and low bits 7..5
      nxt_result_high_byte = sample[RAW_W-1:RES_LO_SHIFT+2];
      // Two compensation bits sit just below, bits 2..0 read zero
      nxt_result_low_byte = {sample[RES_LO_SHIFT+1:0],
                             {RES_LO_SHIFT{1'b0}}};
      nxt_irq = 1'b1;
    end
    // First result clears go; later repeat results leave it at zero
    if (complete && (state_ff == ST_CONV)) begin
      nxt_conversion_go = 1'b0;
    end
    // A start written in the completing cycle wins over the clear
    if (go_start) begin
      nxt_conversion_go = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_go_ff <= CTL0_RESET[GO_BIT];
      ref_level_lo_ff <= CTL0_RESET[REF_LO_BIT];
      ref_to_pin_ff <= CTL0_RESET[REF_PIN_BIT];
      repeat_mode_ff <= CTL0_RESET[REPEAT_BIT];
      input_select_ff <= CTL0_RESET[SEL_MSB:SEL_LSB];
      ref_level_hi_ff <= REF_HI_RESET;
      result_high_byte_ff <= RESULT_RESET;
      result_low_byte_ff <= RESULT_RESET;
      raw_hold_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      conversion_go_ff <= nxt_conversion_go;
      ref_level_lo_ff <= nxt_ref_level_lo;
      ref_to_pin_ff <= nxt_ref_to_pin;
      repeat_mode_ff <= nxt_repeat_mode;
      input_select_ff <= nxt_input_select;
      ref_level_hi_ff <= nxt_ref_level_hi;
      result_high_byte_ff <= nxt_result_high_byte;
      result_low_byte_ff <= nxt_result_low_byte;
      raw_hold_ff <= nxt_raw_hold;
      irq_ff <= nxt_irq;
    end
  end

  // Read mux, sampled in the setup cycle so prdata comes from a flop
  always_comb begin
    nxt_prdata = prdata_ff;
    if (psel && !penable) begin
      nxt_prdata = 32'h0000_0000;
      if (sel_ctl0) begin
        nxt_prdata[GO_BIT] = conversion_go_ff;
        nxt_prdata[REF_LO_BIT] = ref_level_lo_ff;
        nxt_prdata[REF_PIN_BIT] = ref_to_pin_ff;
        nxt_prdata[REPEAT_BIT] = repeat_mode_ff;
        nxt_prdata[SEL_MSB:SEL_LSB] = input_select_ff;
      end else if (sel_ctl1) begin
        nxt_prdata[REF_HI_BIT] = ref_level_hi_ff;
      end else if (sel_res_hi) begin
        nxt_prdata[7:0] = result_high_byte_ff;
      end else if (sel_res_lo) begin
        nxt_prdata[7:0] = result_low_byte_ff;
      end else if (sel_status) begin
        nxt_prdata[ST_POWERED_BIT] = converter_power;
        nxt_prdata[ST_BUSY_BIT] = modulator_run;
        nxt_prdata[ST_REPEATING_BIT] = (state_ff == ST_REPEAT);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;

  // Front end controls follow the sequencer state directly
  assign converter_power = (state_ff != ST_OFF);
  assign modulator_run = (state_ff == ST_CONV) || (state_ff == ST_REPEAT);

  // One-hot switch enables; reserved codes leave every switch open
  always_comb begin
    input_switch_en = '0;
    if (!input_select_ff[3]) begin
      input_switch_en[input_select_ff[2:0]] = modulator_run;
    end
  end

  // Reference code: 00 external pin, 01 low level, 10 high level
  assign ref_level = {ref_level_hi_ff, ref_level_lo_ff};
  // Buffer follows the bit; keeping the reference on is software's job
  assign ref_to_pin = ref_to_pin_ff;
  assign conv_done_irq = irq_ff;

endmodule
`default_nettype wire

// ### verilog/adc_seq_pkg.sv
// Constants shared by the conversion sequencer and its cycle counter
package adc_seq_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [13:0] CTL0_IDX = 14'hF70;
  localparam logic [13:0] CTL1_IDX = 14'hF71;
  localparam logic [13:0] RES_HI_IDX = 14'hF72;
  localparam logic [13:0] RES_LO_IDX = 14'hF73;
  localparam logic [13:0] STATUS_IDX = 14'hF74;

  // Control register 0 field positions
  localparam int GO_BIT = 7;
  localparam int REF_LO_BIT = 6;
  localparam int REF_PIN_BIT = 5;
  localparam int REPEAT_BIT = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 0;

  // Control register 1 field position
  localparam int REF_HI_BIT = 7;

  // Status register field positions
  localparam int ST_POWERED_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_REPEATING_BIT = 2;

  // Reset values
  localparam logic [7:0] CTL0_RESET = 8'h00;
  localparam logic REF_HI_RESET = 1'b1;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // Raw result layout: 13 bits, high byte takes bits 12..5
  localparam int RAW_W = 13;
  localparam int RES_LO_SHIFT = 3;

  // Timing counts in system clock cycles
  localparam int CNT_W = 13;
  localparam logic [12:0] CONV_CYCLES_DEF = 13'h1409;
  localparam logic [12:0] PWRUP_CYCLES = 13'h0028;
  localparam logic [12:0] REPEAT_CYCLES = 13'h0100;
  localparam logic [12:0] IDLE_CYCLES = 13'h00A0;

  // Input select
  localparam int NUM_INPUTS = 8;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_PWRUP = 5'b00010,
    ST_CONV = 5'b00100,
    ST_REPEAT = 5'b01000,
    ST_READY = 5'b10000
  } seq_state_t;

endpackage

// ### verilog/cycle_counter.sv
// Loadable down counter that pulses when a loaded count runs out
`timescale 1ns/1ps
`default_nettype none
module cycle_counter
  import adc_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic clear,
  input wire logic [CNT_W-1:0] load_value,
  output logic expired
);

  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;

  // Load wins over clear so a restart is never dropped
  always_comb begin
    nxt_count = count_ff;
    if (load) begin
      nxt_count = load_value;
    end else if (clear) begin
      nxt_count = '0;
    end else if (count_ff != '0) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Pulse for one cycle, load_value - 1 edges after the loading edge; decoded from
  // the flop alone so the caller may reload on it without a logic loop
  assign expired = (count_ff == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule
`default_nettype wire
